/* sec_err_pkg.sv */
// Purpose: Shared constants and carriers for the secondary bus error status and severity bank.
// Assumes: Configuration accesses arrive as single-cycle dword requests.
// Notes: Offsets are byte addresses within extended configuration space.
package sec_err_pkg;
    localparam logic [11:0] status_offset = 12'h12C;
    localparam logic [11:0] severity_offset = 12'h134;
    localparam logic [31:0] status_reset = 32'h0000_0000;
    localparam logic [31:0] severity_reset = 32'h0000_1340;
    // Bits that hold recorded events.
    localparam logic [31:0] status_live_mask = 32'h0000_1E8C;
    // Bits that software may store in the severity register.
    localparam logic [31:0] severity_write_mask = 32'h0000_3FEE;
    // Bits whose severity steers reporting.
    localparam logic [31:0] severity_effect_mask = 32'h0000_1E8C;
    localparam int system_error_bit = 12;
    localparam int parity_signal_bit = 11;
    localparam int delayed_timeout_bit = 10;
    localparam int address_parity_bit = 9;
    localparam int data_parity_bit = 7;
    localparam int initiator_abort_bit = 3;
    localparam int tgt_abort_bit = 2;

    typedef struct packed {
        logic system_error_seen;
        logic parity_signal_seen;
        logic delayed_timeout;
        logic address_parity_fault;
        logic data_write_parity;
        logic data_read_perr;
        logic initiator_abort;
        logic tgt_abort;
    } event_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cfg_req_type;
endpackage

/* sec_err_bank.sv */
// Purpose: Secondary bus uncorrectable error status and severity registers with fatal/nonfatal reporting.
// Assumes: Event inputs are one-cycle or level pulses synchronous to sys_clk.
// Notes: Read data appears one cycle after the read strobe; unmapped reads return zero.
// Summary of operation
// - Status bit 12 sets when SERR is seen active on the secondary bus.
// - Status bit 11 sets when PERR is seen active on the secondary bus.
// - Status bit 10 sets when a secondary delayed transaction discard timer expires.
// - Status bit 9 sets on an upstream address phase parity error.
// - Status bit 7 sets on write data parity error or PERR on read completion.
// - Status bit 3 sets when a bridge initiated PCI transaction master aborts.
// - Status bit 2 sets when a bridge initiated PCI transaction is target aborted.
// - Status bits 13, 8, 6, 5, 1, 0 are read-only zero.
// - Status bits 31:14 and 4 are read-only zero.
// - Writing one clears a status bit; zeros ignored; only reset clears otherwise.
// - Status and severity return to defaults on fundamental, global or power-on reset.
// - Severity one reports the condition fatal; zero reports it nonfatal.
// - Severity resets to 0000_1340h: SERR and address parity fatal by default.
// - Severity bits 13, 8, 6, 5, 1 are plain storage; bit 0 read-only.
// - Severity bits 31:14 and 4 are read-only zero.
`timescale 1ns/1ps
module sec_err_bank
    import sec_err_pkg::*;
(
    // Clock and resets.
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic fundamental_reset_in,
    input wire logic global_reset_in,
    input wire logic power_on_reset_in,
    // Configuration access.
    input wire cfg_req_type cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // Secondary bus events.
    input wire event_type events,
    // Error reporting.
    output logic err_fatal,
    output logic err_nonfatal
);
    logic [31:0] status;
    logic [31:0] severity;
    logic [31:0] next_status;
    logic [31:0] next_severity;
    logic [31:0] next_rdata;
    logic [31:0] raised;
    logic [31:0] clear_bits;
    logic [31:0] reported;
    function automatic logic offset_hit(input logic [11:0] addr, input logic [11:0] offset);
        return addr == offset;
    endfunction

    function automatic logic any_selected(input logic [31:0] flags, input logic [31:0] sel);
        return |(flags & sel);
    endfunction

    wire any_reset = reset | fundamental_reset_in | global_reset_in | power_on_reset_in;
    wire hit_status = offset_hit(cfg_req.addr, status_offset);
    wire hit_severity = offset_hit(cfg_req.addr, severity_offset);
    wire write_status = cfg_req.wr && hit_status;
    wire write_severity = cfg_req.wr && hit_severity;

    always_comb begin
        raised = 32'h0000_0000;
        raised[system_error_bit] = events.system_error_seen;
        raised[parity_signal_bit] = events.parity_signal_seen;
        raised[delayed_timeout_bit] = events.delayed_timeout;
        raised[address_parity_bit] = events.address_parity_fault;
        raised[data_parity_bit] = events.data_write_parity | events.data_read_perr;
        raised[initiator_abort_bit] = events.initiator_abort;
        raised[tgt_abort_bit] = events.tgt_abort;
    end

    // A new event wins over a clear in the same cycle so nothing is lost.
    assign clear_bits = write_status ? cfg_req.wdata : 32'h0000_0000;
    assign next_status = ((status & ~clear_bits) | raised) & status_live_mask;
    assign next_severity = write_severity
        ? (cfg_req.wdata & severity_write_mask) : severity;
    assign next_rdata = (!cfg_req.rd) ? 32'h0000_0000 : hit_status ? status : hit_severity ? severity : 32'h0000_0000;
    assign reported = status & severity_effect_mask;

    always_ff @(posedge sys_clk) begin
        if (any_reset) begin
            status <= status_reset;
            severity <= severity_reset;
            cfg_rdata <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
            err_fatal <= 1'b0;
            err_nonfatal <= 1'b0;
        end else begin
            status <= next_status;
            severity <= next_severity;
            cfg_rdata <= next_rdata;
            cfg_rvalid <= cfg_req.rd;
            err_fatal <= any_selected(reported, severity);
            err_nonfatal <= any_selected(reported, ~severity);
        end
    end

    property p_set_serr;
        @(posedge sys_clk) disable iff (any_reset) events.system_error_seen |=> status[system_error_bit];
    endproperty
    a_set_serr: assert property (p_set_serr) else $error("SERR event not recorded.");

    property p_set_perr;
        @(posedge sys_clk) disable iff (any_reset) events.parity_signal_seen |=> status[parity_signal_bit];
    endproperty
    a_set_perr: assert property (p_set_perr) else $error("PERR event not recorded.");

    property p_set_timeout;
        @(posedge sys_clk) disable iff (any_reset) events.delayed_timeout |=> status[delayed_timeout_bit];
    endproperty
    a_set_timeout: assert property (p_set_timeout) else $error("Discard timeout not recorded.");

    property p_set_addr;
        @(posedge sys_clk) disable iff (any_reset) events.address_parity_fault |=> status[address_parity_bit];
    endproperty
    a_set_addr: assert property (p_set_addr) else $error("Address parity not recorded.");

    property p_set_data;
        @(posedge sys_clk) disable iff (any_reset)
            (events.data_write_parity || events.data_read_perr) |=> status[data_parity_bit];
    endproperty
    a_set_data: assert property (p_set_data) else $error("Data parity not recorded.");

    property p_set_master_abort;
        @(posedge sys_clk) disable iff (any_reset)
            events.initiator_abort |=> status[initiator_abort_bit];
    endproperty
    a_set_master_abort: assert property (p_set_master_abort) else $error("Master abort not recorded.");

    property p_set_tgt_abort;
        @(posedge sys_clk) disable iff (any_reset)
            events.tgt_abort |=> status[tgt_abort_bit];
    endproperty
    a_set_tgt_abort: assert property (p_set_tgt_abort) else $error("Target abort not recorded.");

    property p_zero_bits;
        @(posedge sys_clk) disable iff (any_reset)
            ((status & ~status_live_mask) == 32'h0000_0000) && ((severity & ~severity_write_mask) == 32'h0000_0000);
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("Read-only zero bits became set.");

    property p_sticky;
        @(posedge sys_clk) disable iff (any_reset)
            status[system_error_bit] && !(cfg_req.wr && hit_status && cfg_req.wdata[system_error_bit])
            |=> status[system_error_bit];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Status flag dropped without a clear.");

    property p_clear;
        @(posedge sys_clk) disable iff (any_reset)
            cfg_req.wr && hit_status && cfg_req.wdata[parity_signal_bit] && !events.parity_signal_seen
            |=> !status[parity_signal_bit];
    endproperty
    a_clear: assert property (p_clear) else $error("Write of one did not clear the flag.");

    property p_reset_val;
        @(posedge sys_clk) any_reset |=> severity == severity_reset && status == status_reset;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("Reset values wrong.");

    property p_fatal;
        @(posedge sys_clk) disable iff (any_reset)
            status[system_error_bit] && severity[system_error_bit] |=> err_fatal;
    endproperty
    a_fatal: assert property (p_fatal) else $error("Fatal condition not reported fatal.");

    property p_nonfatal;
        @(posedge sys_clk) disable iff (any_reset)
            status[tgt_abort_bit] && !severity[tgt_abort_bit] |=> err_nonfatal;
    endproperty
    a_nonfatal: assert property (p_nonfatal) else $error("Nonfatal condition not reported.");

    property p_set_wins;
        @(posedge sys_clk) disable iff (any_reset)
            write_status && cfg_req.wdata[tgt_abort_bit] && events.tgt_abort |=> status[tgt_abort_bit];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Clear beat a new event in the same cycle.");

    property p_sticky_all;
        @(posedge sys_clk) disable iff (any_reset)
            1'b1 |=> (($past(status) & ~$past(clear_bits) & ~status) == 32'h0000_0000);
    endproperty
    a_sticky_all: assert property (p_sticky_all) else $error("A flag dropped without its clear.");

    property p_clear_all;
        @(posedge sys_clk) disable iff (any_reset)
            1'b1 |=> (($past(status) & $past(clear_bits) & ~$past(raised) & status) == 32'h0000_0000);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("A cleared flag stayed set.");

    property p_no_spurious;
        @(posedge sys_clk) disable iff (any_reset)
            1'b1 |=> ((status & ~$past(status) & ~$past(raised)) == 32'h0000_0000);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("A flag rose with no event.");

    property p_double_event;
        @(posedge sys_clk) disable iff (any_reset)
            events.tgt_abort && status[tgt_abort_bit] |=> status[tgt_abort_bit];
    endproperty
    a_double_event: assert property (p_double_event) else $error("Repeated event dropped the flag.");

    property p_zero_write;
        @(posedge sys_clk) disable iff (any_reset)
            write_status && (cfg_req.wdata == 32'h0000_0000) |=> (($past(status) & ~status) == 32'h0000_0000);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("Zero write cleared a flag.");

    property p_flag_level;
        @(posedge sys_clk) disable iff (any_reset)
            status[delayed_timeout_bit] && !write_status |=> status[delayed_timeout_bit];
    endproperty
    a_flag_level: assert property (p_flag_level) else $error("Timeout flag dropped on its own.");

    property p_data_read;
        @(posedge sys_clk) disable iff (any_reset)
            events.data_read_perr |=> status[data_parity_bit];
    endproperty
    a_data_read: assert property (p_data_read) else $error("Read completion parity not recorded.");

    property p_severity_hold;
        @(posedge sys_clk) disable iff (any_reset)
            !write_severity |=> severity == $past(severity);
    endproperty
    a_severity_hold: assert property (p_severity_hold) else $error("Severity changed without a write.");

    property p_severity_write;
        @(posedge sys_clk) disable iff (any_reset)
            write_severity |=> severity == ($past(cfg_req.wdata) & severity_write_mask);
    endproperty
    a_severity_write: assert property (p_severity_write) else $error("Severity write not stored.");

    property p_fatal_any;
        @(posedge sys_clk) disable iff (any_reset)
            ((status & severity_effect_mask & severity) != 32'h0000_0000) |=> err_fatal;
    endproperty
    a_fatal_any: assert property (p_fatal_any) else $error("Fatal flag not reported.");

    property p_nonfatal_any;
        @(posedge sys_clk) disable iff (any_reset)
            ((status & severity_effect_mask & ~severity) != 32'h0000_0000) |=> err_nonfatal;
    endproperty
    a_nonfatal_any: assert property (p_nonfatal_any) else $error("Nonfatal flag not reported.");

    property p_fatal_none;
        @(posedge sys_clk) disable iff (any_reset)
            ((status & severity_effect_mask & severity) == 32'h0000_0000) |=> !err_fatal;
    endproperty
    a_fatal_none: assert property (p_fatal_none) else $error("Fatal reported with no fatal flag.");

    property p_nonfatal_none;
        @(posedge sys_clk) disable iff (any_reset)
            ((status & severity_effect_mask & ~severity) == 32'h0000_0000) |=> !err_nonfatal;
    endproperty
    a_nonfatal_none: assert property (p_nonfatal_none) else $error("Nonfatal reported with no flag.");

    property p_addr_fatal;
        @(posedge sys_clk) disable iff (any_reset)
            status[address_parity_bit] && severity[address_parity_bit] |=> err_fatal;
    endproperty
    a_addr_fatal: assert property (p_addr_fatal) else $error("Address parity not reported fatal.");

    property p_perr_nonfatal;
        @(posedge sys_clk) disable iff (any_reset)
            status[parity_signal_bit] && !severity[parity_signal_bit] |=> err_nonfatal;
    endproperty
    a_perr_nonfatal: assert property (p_perr_nonfatal) else $error("PERR flag not reported nonfatal.");

    property p_reset_outputs;
        @(posedge sys_clk) any_reset |=> !err_fatal && !err_nonfatal && !cfg_rvalid && (cfg_rdata == 32'h0000_0000);
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("Outputs not quiet after reset.");

    property p_read_status;
        @(posedge sys_clk) disable iff (any_reset)
            cfg_req.rd && hit_status |=> cfg_rvalid && (cfg_rdata == $past(status));
    endproperty
    a_read_status: assert property (p_read_status) else $error("Status read returned wrong data.");

    property p_read_severity;
        @(posedge sys_clk) disable iff (any_reset)
            cfg_req.rd && hit_severity |=> cfg_rvalid && (cfg_rdata == $past(severity));
    endproperty
    a_read_severity: assert property (p_read_severity) else $error("Severity read returned wrong data.");

    property p_read_unmapped;
        @(posedge sys_clk) disable iff (any_reset)
            cfg_req.rd && !hit_status && !hit_severity |=> cfg_rvalid && (cfg_rdata == 32'h0000_0000);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("Unmapped read returned data.");

    property p_rvalid_follow;
        @(posedge sys_clk) disable iff (any_reset)
            1'b1 |=> cfg_rvalid == $past(cfg_req.rd);
    endproperty
    a_rvalid_follow: assert property (p_rvalid_follow) else $error("Read valid did not follow the strobe.");

    property p_idle_data;
        @(posedge sys_clk) disable iff (any_reset)
            !cfg_req.rd |=> cfg_rdata == 32'h0000_0000;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("Read data not zero when idle.");

    c_serr_fatal: cover property (@(posedge sys_clk) events.system_error_seen ##2 err_fatal);
    c_clear: cover property (@(posedge sys_clk) status[tgt_abort_bit] ##1 !status[tgt_abort_bit]);
    c_sev_write: cover property (@(posedge sys_clk) cfg_req.wr && hit_severity);
    c_race: cover property (@(posedge sys_clk) cfg_req.wr && hit_status && |raised);
    c_nonfatal: cover property (@(posedge sys_clk) events.tgt_abort ##2 err_nonfatal);
endmodule

/* cfg_host.sv */
// Purpose: Configuration software model issuing dword reads and writes.
// Assumes: Requests change at the falling edge and are taken at the next rising edge.
// Notes: One request is open at a time, which is stricter than the bank needs.
`timescale 1ns/1ps
module cfg_host import sec_err_pkg::*; (
    // Clock.
    input wire logic sys_clk,
    // Configuration access.
    output cfg_req_type cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    initial cfg_req = '0;
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge sys_clk) cfg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge sys_clk) cfg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output bit ok);
        ok = 1'b0;
        d = '0;
        @(negedge sys_clk) cfg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
        for (int n = 0; n < 3 && !ok; n++) begin
            @(negedge sys_clk) cfg_req.rd <= 1'b0;
            if (cfg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = cfg_rdata;
            end
        end
    endtask
endmodule

/* sec_err_bank_tb.sv */
// Purpose: Self-checking bench for the secondary error status and severity bank.
// Assumes: Inputs change at the falling clock edge.
// Notes: Events are pulsed one at a time, so each flag maps to one expectation.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module sec_err_bank_tb import sec_err_pkg::*; ;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] xrst = 3'h0;
    event_type events = '0;
    cfg_req_type cfg_req;
    logic [31:0] cfg_rdata;
    logic cfg_rvalid, err_fatal, err_nonfatal;
    int err_count = 0;
    int tests_run = 0;
    int pos [8] = '{2, 3, 7, 7, 9, 10, 11, 12};
    initial forever #20 sys_clk = ~sys_clk;
    sec_err_bank dut_u (.sys_clk(sys_clk), .reset(reset), .fundamental_reset_in(xrst[0]),
        .global_reset_in(xrst[1]), .power_on_reset_in(xrst[2]), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .events(events), .err_fatal(err_fatal), .err_nonfatal(err_nonfatal));
    cfg_host host_u (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] d;
        bit ok;
        host_u.rd(a, d, ok);
        if (!ok) begin
            err_count++;
            summarize();
        end else begin
            `CHK(n, e, d)
        end
    endtask
    task automatic pulse(input int i);
        @(negedge sys_clk) events <= event_type'(8'h01 << i);
        @(negedge sys_clk) events <= '0;
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        reset <= 1'b0;
        rdchk(status_offset, 32'h0000_0000, "status reset");
        rdchk(severity_offset, 32'h0000_1340, "severity reset");
        host_u.wr(severity_offset, 32'hFFFF_FFFF);
        rdchk(severity_offset, 32'h0000_3FEE, "severity writable");
        host_u.wr(severity_offset, 32'h0000_1340);
        host_u.wr(status_offset, 32'hFFFF_FFFF);
        rdchk(status_offset, 32'h0000_0000, "status read-only");
        rdchk(12'h130, 32'h0000_0000, "unmapped");
        // Each event twice, then a zero write, so sticky and ignored-zero cases share one pass.
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            pulse(i);
            host_u.wr(status_offset, 32'h0000_0000);
            rdchk(status_offset, 32'h1 << pos[i], "flag");
            `CHK("fatal", pos[i] == 12 || pos[i] == 9, err_fatal)
            `CHK("nonfatal", pos[i] != 12 && pos[i] != 9, err_nonfatal)
            host_u.wr(status_offset, 32'h1 << pos[i]);
            rdchk(status_offset, 32'h0000_0000, "flag clear");
        end
        // An event and its own clear land on one edge; the event must survive.
        fork
            host_u.wr(status_offset, 32'h0000_0004);
            pulse(0);
        join
        rdchk(status_offset, 32'h0000_0004, "set beats clear");
        host_u.wr(status_offset, 32'h0000_0004);
        rdchk(status_offset, 32'h0000_0000, "race flag clear");
        host_u.wr(severity_offset, 32'h0000_0000);
        pulse(7);
        repeat (3) @(negedge sys_clk);
        `CHK("flip fatal", 1'b0, err_fatal)
        `CHK("flip nonfatal", 1'b1, err_nonfatal)
        for (int k = 0; k < 3; k++) begin
            pulse(0);
            @(negedge sys_clk) xrst <= 3'h1 << k;
            @(negedge sys_clk) xrst <= 3'h0;
            rdchk(status_offset, 32'h0000_0000, "status after reset");
            rdchk(severity_offset, 32'h0000_1340, "severity after reset");
            host_u.wr(severity_offset, 32'h0000_0000);
        end
        summarize();
    end
endmodule
